// file: dv/testbench.sv
// Self-checking bench for the loop divider and spread configuration block.
// Assumes pds_config answers APB with zero wait states and checks its own assertions.
`timescale 1ns/1ns
module testbench;
   import pds_pkg::*;
   logic                             ref_clk, rstn, psel, penable, pwrite, out_step;
   logic [ADDR_W-1:0]                paddr;
   logic [31:0]                      pwdata, prdata, rd;
   logic                             pready, pslverr, osc_select_n, ss_dir_down, err;
   pds_loop_cfg_type [NUM_LOOPS-1:0] loop_cfg;
   pds_ss_cfg_type                   ss_cfg;
   logic [10:0]                      ss_phase, maxph;
   logic [7:0]                       ref_e [4];
   logic [7:0]                       post_e [4];
   logic [10:0]                      fb_e [4];
   logic                             pre_e [4];
   logic [12:0]                      rat;
   logic [10:0]                      amp;
   int                               failures, samples_checked, ndown;

   pds_config u_dut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .out_step(out_step), .loop_cfg(loop_cfg), .ss_cfg(ss_cfg),
      .osc_select_n(osc_select_n), .ss_phase(ss_phase), .ss_dir_down(ss_dir_down));

   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   task tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish

   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Request held from setup until pready is seen high at a rising edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1 && n < 50)
      begin
         n++;
         @(posedge ref_clk);
      end
      if (n >= 50)
         failures++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   function automatic logic [31:0] loop_word(int i);
      return {11'h000, (i == 0 || i == 3) ? pre_e[i] : 1'b0, 1'b0, fb_e[i], ref_e[i]};
   endfunction : loop_word

   function automatic logic [2:0] prediv_exp(int i);
      if (i == 1)
         return PREDIV_X4;
      if (i == 2)
         return PREDIV_X1;
      return pre_e[i] ? PREDIV_X4 : PREDIV_X1;
   endfunction : prediv_exp

   function automatic logic [3:0] bad_exp();
      logic [3:0] b;
      for (int i = 0; i < 4; i++)
         b[i] = (ref_e[i] < REF_DIV_MIN) || (fb_e[i] < FB_DIV_MIN);
      return b;
   endfunction : bad_exp

   task check_loop(input int i);
      apb(1'b0, OFS_LOOP0 + 8'(4 * i), 32'h0);
      chk(rd, loop_word(i));
      apb(1'b0, OFS_POST0 + 8'(4 * i), 32'h0);
      chk(rd, {24'h0, post_e[i]});
      chk(32'(loop_cfg[i]), 32'({ref_e[i], fb_e[i], prediv_exp(i), post_e[i]}));
   endtask : check_loop

   task check_status(input logic act);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk({27'h0, rd[4:0]}, {27'h0, act, bad_exp()});
   endtask : check_status

   task set_loop(input int i);
      apb(1'b1, OFS_LOOP0 + 8'(4 * i), {11'h000, pre_e[i], 1'b0, fb_e[i], ref_e[i]});
      apb(1'b1, OFS_POST0 + 8'(4 * i), {24'h0, post_e[i]});
   endtask : set_loop

   initial
   begin
      #500_000;
      failures++;
      tally_and_finish();
   end

   initial
   begin
      {rstn, psel, penable, pwrite, out_step, paddr, pwdata} = '0;
      failures = 0;
      samples_checked = 0;
      void'($urandom(42));
      repeat (10) @(posedge ref_clk);
      rstn <= 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         {ref_e[i], fb_e[i], pre_e[i], post_e[i]} = {RST_REF_DIV, RST_FB_DIV, 1'b0, RST_POST_DIV};
         check_loop(i);
      end
      apb(1'b0, OFS_CTRL, 32'h0);
      chk(rd, 32'h3);
      apb(1'b0, OFS_SS_PERIOD, 32'h0);
      chk(rd, 32'(RST_SS_PERIOD));
      apb(1'b0, OFS_SS_RATIO, 32'h0);
      chk(rd, 32'(RST_SS_RATIO));
      apb(1'b0, OFS_SS_AMP, 32'h0);
      chk(rd, 32'(RST_SS_AMP));
      check_status(1'b0);
      $display("test reset values done");
      // Boundary values first, then random legal settings
      for (int rep = 0; rep < 6; rep++)
         for (int i = 0; i < 4; i++)
         begin
            ref_e[i] = (rep == 0) ? 8'hFF : 8'(1 + $urandom % 255);
            fb_e[i] = (rep == 0) ? 11'h7FF : (rep == 1) ? 11'h006 : 11'(6 + $urandom % 2042);
            pre_e[i] = 1'($urandom);
            post_e[i] = (rep == 0) ? 8'hFF : 8'($urandom);
            set_loop(i);
            check_loop(i);
         end
      check_status(1'b0);
      $display("test divider settings done");
      ref_e[0] = 8'h00;
      fb_e[2] = 11'h005;
      set_loop(0);
      set_loop(2);
      check_status(1'b0);
      ref_e[0] = 8'h01;
      fb_e[2] = 11'h006;
      set_loop(0);
      set_loop(2);
      apb(1'b1, 8'h34, 32'hFFFF_FFFF);
      chk(32'(err), 32'h1);
      apb(1'b0, 8'hFC, 32'h0);
      chk(32'(err), 32'h1);
      apb(1'b0, OFS_CTRL, 32'h0);
      chk({rd[31:2], err}, 31'h0);
      $display("test range and decode done");
      rat = 13'($urandom);
      amp = 11'($urandom);
      apb(1'b1, OFS_SS_PERIOD, 32'h8);
      apb(1'b1, OFS_SS_RATIO, 32'(rat));
      apb(1'b1, OFS_SS_AMP, 32'(amp));
      apb(1'b1, OFS_CTRL, 32'h0);
      out_step <= 1'b1;
      repeat (6) @(posedge ref_clk);
      chk(32'(ss_cfg), 32'({1'b1, rat, amp, 11'h008}));
      chk(32'({ss_cfg.active, ss_cfg.spread_ratio}), 32'({1'b1, rat}));
      chk(32'(osc_select_n), 32'h0);
      maxph = 11'h000;
      ndown = 0;
      repeat (40)
      begin
         @(posedge ref_clk);
         if (ss_phase > maxph)
            maxph = ss_phase;
         if (ss_dir_down)
            ndown++;
      end
      chk(32'(maxph), 32'h4);
      chk(32'(ndown), 32'h14);
      check_status(1'b1);
      apb(1'b1, OFS_SS_PERIOD, 32'h7);
      repeat (3) @(posedge ref_clk);
      chk(32'(ss_cfg.active), 32'h0);
      apb(1'b1, OFS_SS_PERIOD, 32'h8);
      apb(1'b1, OFS_CTRL, 32'h1);
      repeat (3) @(posedge ref_clk);
      chk(32'(ss_cfg.active), 32'h0);
      apb(1'b1, OFS_CTRL, 32'h2);
      out_step <= 1'b0;
      repeat (6) @(posedge ref_clk);
      chk(32'(ss_cfg.active), 32'h0);
      chk(32'(osc_select_n), 32'h1);
      $display("test spread done");
      tally_and_finish();
   end
endmodule : testbench

// file: rtl/pds_config.sv
// Configuration registers for four synthesis loops, their post-dividers and spread.
// Assumes an APB master on ref_clk; the analogue loops read the cfg outputs.
`timescale 1ns/1ns
module pds_config
   import pds_pkg::*;
(
   input  wire logic                       ref_clk,
   input  wire logic                       rstn,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [ADDR_W-1:0]          paddr,
   input  wire logic [31:0]                pwdata,
   output logic [31:0]                     prdata,
   output logic                            pready,
   output logic                            pslverr,
   input  wire logic                       out_step,
   output pds_loop_cfg_type [NUM_LOOPS-1:0] loop_cfg,
   output pds_ss_cfg_type                  ss_cfg,
   output logic                            osc_select_n,
   output logic [10:0]                     ss_phase,
   output logic                            ss_dir_down
);
   import pds_pkg::*;

   logic [7:0]  ref_div_ff   [NUM_LOOPS];
   logic [10:0] fb_div_ff    [NUM_LOOPS];
   logic        prediv_ff    [NUM_LOOPS];
   logic [7:0]  post_div_ff  [NUM_LOOPS];
   logic        spread_disable_n_ff;
   logic        osc_select_n_ff;
   logic [10:0] period_ff;
   logic [12:0] spread_ratio_ff;
   logic [10:0] spread_amplitude_ff;
   logic [31:0] prdata_ff;
   logic        pslverr_ff;
   logic [NUM_LOOPS-1:0] bad;
   logic        wr_en;
   logic        rd_en;
   logic        step_sync1_ff;
   logic        step_sync2_ff;
   logic        wrap;

   // Legal programming range check for one loop
   function automatic logic out_of_range(input logic [7:0] r, input logic [10:0] f);
      out_of_range = (r < REF_DIV_MIN) || (f < FB_DIV_MIN);
   endfunction : out_of_range

   // Register slot decode used by read and write
   function automatic logic hit_loop(input logic [ADDR_W-1:0] a, input int unsigned i,
                                     input logic [7:0] base);
      hit_loop = (a == ADDR_W'(base + 8'(i * 4)));
   endfunction : hit_loop

   // Zero-wait slave: every access completes in its first access cycle
   assign pready  = 1'b1;
   assign wr_en   = psel && penable && pwrite;
   assign rd_en   = psel && !penable && !pwrite;
   assign prdata  = prdata_ff;
   assign pslverr = pslverr_ff;

   genvar g;
   generate
      for (g = 0; g < NUM_LOOPS; g++)
      begin : g_loop
         always_ff @(posedge ref_clk)
         begin
            if (!rstn)
            begin
               ref_div_ff[g]  <= RST_REF_DIV;
               fb_div_ff[g]   <= RST_FB_DIV;
               prediv_ff[g]   <= 1'b0;
               post_div_ff[g] <= RST_POST_DIV;
            end
            else if (wr_en && hit_loop(paddr, g, OFS_LOOP0))
            begin
               // Applied at once; outputs may glitch, which software tolerates
               ref_div_ff[g] <= pwdata[LP_REF_LSB +: REF_DIV_W];
               fb_div_ff[g]  <= pwdata[LP_FB_LSB +: FB_DIV_W];
               // Pre-divider select exists only on loops 0 and 3
               prediv_ff[g]  <= (g == 0 || g == 3) ? pwdata[LP_PRE_BIT] : 1'b0;
            end
            else if (wr_en && hit_loop(paddr, g, OFS_POST0))
               post_div_ff[g] <= pwdata[POST_DIV_W-1:0];
         end

         assign bad[g] = out_of_range(ref_div_ff[g], fb_div_ff[g]);
         assign loop_cfg[g].ref_div         = ref_div_ff[g];
         assign loop_cfg[g].fb_div          = fb_div_ff[g];
         // Loop 1 runs a fixed four; others one unless selected
         assign loop_cfg[g].feedback_prediv =
            (g == 1) ? PREDIV_X4 : (prediv_ff[g] ? PREDIV_X4 : PREDIV_X1);
         assign loop_cfg[g].post_divider    = post_div_ff[g];
      end
   endgenerate

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         spread_disable_n_ff <= 1'b1;
         osc_select_n_ff     <= 1'b1;
      end
      else if (wr_en && paddr == OFS_CTRL)
      begin
         spread_disable_n_ff <= pwdata[CT_SSDIS_BIT];
         osc_select_n_ff     <= pwdata[CT_OSC_BIT];
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         period_ff           <= RST_SS_PERIOD;
         spread_ratio_ff     <= RST_SS_RATIO;
         spread_amplitude_ff <= RST_SS_AMP;
      end
      else if (wr_en)
      begin
         if (paddr == OFS_SS_PERIOD)
            period_ff <= pwdata[SS_PERIOD_W-1:0];
         if (paddr == OFS_SS_RATIO)
            spread_ratio_ff <= pwdata[SS_RATIO_W-1:0];
         if (paddr == OFS_SS_AMP)
            spread_amplitude_ff <= pwdata[SS_AMP_W-1:0];
      end
   end

   // Read data captured in setup so it is stable across the access phase
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         prdata_ff  <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end
      else if (psel && !penable)
      begin
         prdata_ff  <= 32'h0000_0000;
         pslverr_ff <= 1'b1;
         for (int i = 0; i < NUM_LOOPS; i++)
         begin
            if (hit_loop(paddr, i, OFS_LOOP0))
            begin
               pslverr_ff <= 1'b0;
               if (rd_en)
                  prdata_ff <= {11'h000, prediv_ff[i], 1'b0, fb_div_ff[i], ref_div_ff[i]};
            end
            if (hit_loop(paddr, i, OFS_POST0))
            begin
               pslverr_ff <= 1'b0;
               if (rd_en)
                  prdata_ff <= {24'h00_0000, post_div_ff[i]};
            end
         end
         case (paddr)
            OFS_CTRL:
            begin
               pslverr_ff <= 1'b0;
               if (rd_en)
                  prdata_ff <= {30'h0000_0000, osc_select_n_ff, spread_disable_n_ff};
            end
            OFS_SS_PERIOD:
            begin
               pslverr_ff <= 1'b0;
               if (rd_en)
                  prdata_ff <= {21'h00_0000, period_ff};
            end
            OFS_SS_RATIO:
            begin
               pslverr_ff <= 1'b0;
               if (rd_en)
                  prdata_ff <= {19'h0_0000, spread_ratio_ff};
            end
            OFS_SS_AMP:
            begin
               pslverr_ff <= 1'b0;
               if (rd_en)
                  prdata_ff <= {21'h00_0000, spread_amplitude_ff};
            end
            OFS_STATUS:
            begin
               pslverr_ff <= 1'b0;
               if (rd_en)
                  prdata_ff <= {26'h000_0000, ss_dir_down, ss_cfg.active, bad};
            end
            default:
            begin
            end
         endcase
      end
   end

   // Output step pulses come from the analogue side, so synchronise them
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         step_sync1_ff <= 1'b0;
         step_sync2_ff <= 1'b0;
      end
      else
      begin
         step_sync1_ff <= out_step;
         step_sync2_ff <= step_sync1_ff;
      end
   end

   // Spread only on loop 1, and only with legal dividers and an even period
   assign ss_cfg.active = !spread_disable_n_ff && !bad[1] && !period_ff[0]
                          && step_sync2_ff;
   assign ss_cfg.spread_ratio     = spread_ratio_ff;
   assign ss_cfg.spread_amplitude = spread_amplitude_ff;
   assign ss_cfg.period           = period_ff;
   assign osc_select_n            = osc_select_n_ff;

   pds_spread_mod u_mod
   (
      .ref_clk     (ref_clk),
      .rstn        (rstn),
      .cfg         (ss_cfg),
      .phase_ff    (ss_phase),
      .dir_down_ff (ss_dir_down),
      .wrap_ff     (wrap)
   );

   a_write_ctrl: assert property (@(posedge ref_clk) disable iff (!rstn)
      wr_en && paddr == OFS_CTRL |=> spread_disable_n_ff == $past(pwdata[0]))
      else $error("control write lost");
   a_prediv_only: assert property (@(posedge ref_clk) disable iff (!rstn)
      !prediv_ff[1] && !prediv_ff[2]) else $error("pre-divider on wrong loop");
   a_loop1_four: assert property (@(posedge ref_clk) disable iff (!rstn)
      loop_cfg[1].feedback_prediv == PREDIV_X4) else $error("loop 1 pre-divider");
   a_range_flag: assert property (@(posedge ref_clk) disable iff (!rstn)
      wr_en && paddr == OFS_LOOP0 && pwdata[7:0] == 8'h00 |=> bad[0])
      else $error("zero reference divider not flagged");
   a_ss_blocked: assert property (@(posedge ref_clk) disable iff (!rstn)
      spread_disable_n_ff |-> !ss_cfg.active) else $error("spread while disabled");
   a_odd_period: assert property (@(posedge ref_clk) disable iff (!rstn)
      period_ff[0] |-> !ss_cfg.active) else $error("odd period spreading");
   a_post_write: assert property (@(posedge ref_clk) disable iff (!rstn)
      wr_en && paddr == OFS_POST0 |=> post_div_ff[0] == $past(pwdata[7:0]))
      else $error("post-divider write lost");
   a_unmapped_err: assert property (@(posedge ref_clk) disable iff (!rstn)
      psel && !penable && paddr == 8'hFC |=> pslverr) else $error("unmapped not refused");
   a_wrap_up: assert property (@(posedge ref_clk) disable iff (!rstn)
      wrap |-> !ss_dir_down && ss_phase == 11'h000) else $error("wrap not at bottom");
   c_ss_on: cover property (@(posedge ref_clk) disable iff (!rstn) ss_cfg.active);
   c_read_status: cover property (@(posedge ref_clk) disable iff (!rstn)
      rd_en && paddr == OFS_STATUS);
   c_prediv_set: cover property (@(posedge ref_clk) disable iff (!rstn) prediv_ff[3]);
endmodule : pds_config

// file: rtl/pds_pkg.sv
// Package for the synthesis-loop divider and spread configuration block.
// Assumes an APB slave with 32-bit data; all registers are aligned words.
package pds_pkg;
   localparam int unsigned NUM_LOOPS       = 4;
   localparam int unsigned REF_DIV_W       = 8;
   localparam int unsigned FB_DIV_W        = 11;
   localparam int unsigned POST_DIV_W      = 8;
   localparam int unsigned SS_PERIOD_W     = 11;
   localparam int unsigned SS_RATIO_W      = 13;
   localparam int unsigned SS_AMP_W        = 11;
   localparam int unsigned ADDR_W          = 8;

   // Register byte offsets
   localparam logic [7:0]  OFS_LOOP0       = 8'h00;
   localparam logic [7:0]  OFS_LOOP_STEP   = 8'h04;
   localparam logic [7:0]  OFS_POST0       = 8'h10;
   localparam logic [7:0]  OFS_CTRL        = 8'h20;
   localparam logic [7:0]  OFS_SS_PERIOD   = 8'h24;
   localparam logic [7:0]  OFS_SS_RATIO    = 8'h28;
   localparam logic [7:0]  OFS_SS_AMP      = 8'h2C;
   localparam logic [7:0]  OFS_STATUS      = 8'h30;

   // Loop register fields
   localparam int unsigned LP_REF_LSB      = 0;
   localparam int unsigned LP_FB_LSB       = 8;
   localparam int unsigned LP_PRE_BIT      = 20;
   // Control register fields
   localparam int unsigned CT_SSDIS_BIT    = 0;
   localparam int unsigned CT_OSC_BIT      = 1;
   // Status register fields
   localparam int unsigned ST_BAD_LSB      = 0;
   localparam int unsigned ST_SS_ON_BIT    = 4;
   localparam int unsigned ST_DIR_BIT      = 5;

   // Legal ranges
   localparam logic [7:0]  REF_DIV_MIN     = 8'h01;
   localparam logic [10:0] FB_DIV_MIN      = 11'h006;

   // Reset values
   localparam logic [7:0]  RST_REF_DIV     = 8'h01;
   localparam logic [10:0] RST_FB_DIV      = 11'h006;
   localparam logic [7:0]  RST_POST_DIV    = 8'h01;
   localparam logic [10:0] RST_SS_PERIOD   = 11'h280;
   localparam logic [12:0] RST_SS_RATIO    = 13'h00A0;
   localparam logic [10:0] RST_SS_AMP      = 11'h141;

   // Fixed pre-divider ratios
   localparam logic [2:0]  PREDIV_X1       = 3'h1;
   localparam logic [2:0]  PREDIV_X4       = 3'h4;

   typedef struct packed {
      logic [7:0]  ref_div;
      logic [10:0] fb_div;
      logic [2:0]  feedback_prediv;
      logic [7:0]  post_divider;
   } pds_loop_cfg_type;

   typedef struct packed {
      logic        active;
      logic [12:0] spread_ratio;
      logic [10:0] spread_amplitude;
      logic [10:0] period;
   } pds_ss_cfg_type;

   typedef enum logic [1:0] {
      SS_IDLE = 2'b00,
      SS_UP   = 2'b01,
      SS_DOWN = 2'b11
   } pds_ss_state_type;
endpackage : pds_pkg

// file: rtl/pds_spread_mod.sv
// Triangle step generator for the spread modulator of loop 1.
// Assumes cfg.active already folds in the synchronised output-step level.
`timescale 1ns/1ns
module pds_spread_mod
   import pds_pkg::*;
(
   input  wire logic            ref_clk,
   input  wire logic            rstn,
   input  wire pds_ss_cfg_type  cfg,
   output logic [10:0]          phase_ff,
   output logic                 dir_down_ff,
   output logic                 wrap_ff
);
   pds_ss_state_type state_ff;
   logic [10:0]      half;

   // Half period; an odd count loses its last step, hence even counts only
   assign half = cfg.period >> 1;

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         state_ff    <= SS_IDLE;
         phase_ff    <= 11'h000;
         dir_down_ff <= 1'b0;
         wrap_ff     <= 1'b0;
      end
      else
      begin
         wrap_ff <= 1'b0;
         case (state_ff)
            SS_IDLE:
            begin
               phase_ff    <= 11'h000;
               dir_down_ff <= 1'b0;
               if (cfg.active && half != 11'h000)
                  state_ff <= SS_UP;
            end
            SS_UP:
            begin
               if (!cfg.active)
                  state_ff <= SS_IDLE;
               else if (phase_ff + 11'h001 >= half)
               begin
                  phase_ff    <= half;
                  dir_down_ff <= 1'b1;
                  state_ff    <= SS_DOWN;
               end
               else
                  phase_ff <= phase_ff + 11'h001;
            end
            SS_DOWN:
            begin
               if (!cfg.active)
                  state_ff <= SS_IDLE;
               else if (phase_ff <= 11'h001)
               begin
                  phase_ff    <= 11'h000;
                  dir_down_ff <= 1'b0;
                  wrap_ff     <= 1'b1;
                  state_ff    <= SS_UP;
               end
               else
                  phase_ff <= phase_ff - 11'h001;
            end
            default:
               state_ff <= SS_IDLE;
         endcase
      end
   end

   a_phase_bound: assert property (@(posedge ref_clk) disable iff (!rstn)
      phase_ff <= half || !cfg.active) else $error("phase beyond half period");
   a_idle_off: assert property (@(posedge ref_clk) disable iff (!rstn)
      !cfg.active |=> (state_ff == SS_IDLE)) else $error("spread not stopped");
   c_wrap: cover property (@(posedge ref_clk) disable iff (!rstn) wrap_ff);
endmodule : pds_spread_mod
